//--- rtl/rsd_diag.sv
// rsd_diag.sv: resolver feedback diagnostics with host register port
//
// Decided for this implementation: the placing of the registers and strobed register access.
`default_nettype none
`include "rsd_cfg.svh"

module rsd_diag
#(
   parameter int W = `RSD_DW
)
(
   input  wire logic                   clk_sys,
   input  wire logic                   rstn,
   input  wire logic                   upd_valid,
   input  wire logic                   upd_half,
   input  wire logic signed [W-1:0]    upd_sin,
   input  wire logic signed [W-1:0]    upd_cos,
   input  wire logic signed [W-1:0]    upd_ang_err,
   input  wire logic signed [W-1:0]    upd_speed,
   input  wire rsd_pkg::rsd_bus_s      bus,
   output logic [31:0]                 rdata,
   output rsd_pkg::rsd_flags_s         flags_act,
   output rsd_pkg::rsd_flags_s         flags_cum,
   output rsd_pkg::rsd_dec_s           faults,
   output logic                        busy
);
   import rsd_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic                          run;
      logic                          fresh;
      logic                          calc;
      logic signed [W-1:0]           sa1;
      logic signed [W-1:0]           sa2;
      logic signed [W-1:0]           ca1;
      logic signed [W-1:0]           ca2;
      logic [W-1:0]                  cur_s;
      logic [W-1:0]                  cur_c;
      logic [W-1:0]                  err;
      logic [W-1:0]                  spd;
      logic [W-1:0]                  samin;
      logic [W-1:0]                  samax;
      logic [W-1:0]                  camin;
      logic [W-1:0]                  camax;
      logic signed [W-1:0]           sm;
      logic signed [W-1:0]           cm;
      logic signed [W-1:0]           smmin;
      logic signed [W-1:0]           smmax;
      logic signed [W-1:0]           cmmin;
      logic signed [W-1:0]           cmmax;
      logic [W:0]                    vec;
      logic [W:0]                    vmin;
      logic [W:0]                    vmax;
      logic signed [W:0]             diff;
      logic [`RSD_NLIM-1:0][W:0]     lim;
      rsd_flags_s                    act;
      rsd_flags_s                    cum;
      rsd_dec_s                      dec;
      logic [31:0]                   rdata;
   } rsd_state_s;

   // low limit resets to zero so it never fires; the others to full scale
   localparam logic [`RSD_NLIM-1:0][W:0] LIM_RST = '{`RSD_LIM_RLOW: '0, default: '1};
   localparam rsd_state_s ST_RST = '{run: `RSD_RUN_RST, fresh: 1'b1, lim: LIM_RST, default: '0};

   rsd_state_s                st_q;
   rsd_state_s                st_d;

   logic                      diag_rst;
   logic signed [W:0]         sum_s;
   logic signed [W:0]         sum_c;
   logic [2*W-1:0]            sq_s;
   logic [2*W-1:0]            sq_c;
   logic [2*W-1:0]            sq_sum;
   logic [W:0]                vec_n;
   logic signed [W:0]         d_sc;
   logic signed [W:0]         d_cs;
   rsd_flags_s                f;
   rsd_flags_s                cum_n;
   logic [7:0]                moff;
   logic [7:0]                midx;
   logic [31:0]               rdv [`RSD_NMEAS];

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [W-1:0] f_abs(input logic signed [W-1:0] x);
      logic [W-1:0] r;
      r = x[W-1] ? W'(-x) : W'(x);
      return r;
   endfunction : f_abs

   function automatic logic [W:0] f_zx(input logic [W-1:0] x);
      return {1'b0, x};
   endfunction : f_zx

   function automatic logic [31:0] f_sx(input logic signed [W-1:0] x);
      return 32'(x);
   endfunction : f_sx

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      st_d     = st_q;
      diag_rst = 1'b0;
      sum_s    = '0;
      sum_c    = '0;
      sq_s     = '0;
      sq_c     = '0;
      sq_sum   = '0;
      vec_n    = '0;
      d_sc     = '0;
      d_cs     = '0;
      f        = '0;
      cum_n    = st_q.cum;
      moff     = bus.addr - `RSD_A_MEAS0;
      midx     = moff >> 2;
      st_d.calc = 1'b0;

      // register writes
      if (bus.wr)
      begin
         if (bus.addr == `RSD_A_CTRL)
         begin
            st_d.run = bus.wdata[`RSD_CTRL_RUN_BIT];
            diag_rst = bus.wdata[`RSD_CTRL_RST_BIT];
         end
         for (int i = 0; i < `RSD_NLIM; i++)
         begin
            if (bus.addr == 8'(`RSD_A_LIM0 + i * `RSD_WORD))
            begin
               st_d.lim[i] = bus.wdata[W:0];
            end
         end
      end

      // capture one update; first half goes to the positive slot
      if (upd_valid && st_q.run)
      begin
         if (upd_half == `RSD_HALF_FIRST)
         begin
            st_d.sa1 = upd_sin;
            st_d.ca1 = upd_cos;
         end
         else
         begin
            st_d.sa2 = upd_sin;
            st_d.ca2 = upd_cos;
         end
         st_d.cur_s = f_abs(upd_sin);
         st_d.cur_c = f_abs(upd_cos);
         st_d.err   = f_abs(upd_ang_err);
         st_d.spd   = f_abs(upd_speed);
         st_d.calc  = 1'b1;
      end

      // evaluation pass, one cycle after capture
      if (st_q.calc)
      begin
         // negative half carries minus the amplitude, so the sum leaves the dc part
         // one spare bit so two full-scale halves cannot wrap
         sum_s   = (W + 1)'(st_q.sa1) + (W + 1)'(st_q.sa2);
         sum_c   = (W + 1)'(st_q.ca1) + (W + 1)'(st_q.ca2);
         st_d.sm = sum_s[W:1];
         st_d.cm = sum_c[W:1];

         // fractional squares; drop the extra integer scaling
         sq_s    = st_q.cur_s * st_q.cur_s;
         sq_c    = st_q.cur_c * st_q.cur_c;
         sq_sum  = sq_s + sq_c;
         vec_n   = sq_sum[2*W-1:W-1];
         st_d.vec = vec_n;

         // diagnostics reset in the same cycle seeds from this pass
         if (st_q.fresh || diag_rst)
         begin
            st_d.samin = st_q.cur_s;
            st_d.samax = st_q.cur_s;
            st_d.camin = st_q.cur_c;
            st_d.camax = st_q.cur_c;
            st_d.smmin = st_d.sm;
            st_d.smmax = st_d.sm;
            st_d.cmmin = st_d.cm;
            st_d.cmmax = st_d.cm;
            st_d.vmin  = vec_n;
            st_d.vmax  = vec_n;
         end
         else
         begin
            if (st_q.cur_s < st_q.samin) st_d.samin = st_q.cur_s;
            if (st_q.cur_s > st_q.samax) st_d.samax = st_q.cur_s;
            if (st_q.cur_c < st_q.camin) st_d.camin = st_q.cur_c;
            if (st_q.cur_c > st_q.camax) st_d.camax = st_q.cur_c;
            if (st_d.sm < st_q.smmin) st_d.smmin = st_d.sm;
            if (st_d.sm > st_q.smmax) st_d.smmax = st_d.sm;
            if (st_d.cm < st_q.cmmin) st_d.cmmin = st_d.cm;
            if (st_d.cm > st_q.cmmax) st_d.cmmax = st_d.cm;
            if (vec_n < st_q.vmin) st_d.vmin = vec_n;
            if (vec_n > st_q.vmax) st_d.vmax = vec_n;
         end
         st_d.fresh = 1'b0;

         // worse of the two cross differences
         d_sc = $signed(f_zx(st_d.samax)) - $signed(f_zx(st_d.camin));
         d_cs = $signed(f_zx(st_d.camax)) - $signed(f_zx(st_d.samin));
         st_d.diff = (d_sc > d_cs) ? d_sc : d_cs;

         // threshold comparisons
         f.sin_ampl    = (f_zx(f_abs(st_q.sa1)) > st_q.lim[`RSD_LIM_AMPL])
                       || (f_zx(f_abs(st_q.sa2)) > st_q.lim[`RSD_LIM_AMPL]);
         f.cos_ampl    = (f_zx(f_abs(st_q.ca1)) > st_q.lim[`RSD_LIM_AMPL])
                       || (f_zx(f_abs(st_q.ca2)) > st_q.lim[`RSD_LIM_AMPL]);
         f.sin_mean    = f_zx(f_abs(st_d.sm)) > st_q.lim[`RSD_LIM_OFFS];
         f.cos_mean    = f_zx(f_abs(st_d.cm)) > st_q.lim[`RSD_LIM_OFFS];
         f.radius_low  = vec_n < st_q.lim[`RSD_LIM_RLOW];
         f.radius_high = vec_n > st_q.lim[`RSD_LIM_RHIGH];
         // negative deformation can never exceed an unsigned limit
         f.deform      = !st_d.diff[W] && (f_zx(st_d.diff[W-1:0]) > st_q.lim[`RSD_LIM_DEF]);
         f.track_err   = f_zx(st_q.err) > st_q.lim[`RSD_LIM_TERR];
         f.overspeed   = f_zx(st_q.spd) > st_q.lim[`RSD_LIM_SPD];
         st_d.act      = f;

         // new detection wins over a clear in the same cycle
         cum_n = diag_rst ? f : (st_q.cum | f);
      end
      else if (diag_rst)
      begin
         cum_n      = '0;
         st_d.fresh = 1'b1;
         st_d.samin = '0;
         st_d.samax = '0;
         st_d.camin = '0;
         st_d.camax = '0;
         st_d.smmin = '0;
         st_d.smmax = '0;
         st_d.cmmin = '0;
         st_d.cmmax = '0;
         st_d.vmin  = '0;
         st_d.vmax  = '0;
         st_d.diff  = '0;
      end
      st_d.cum = cum_n;

      // decoding follows the cumulative field so no fault slips between reads
      st_d.dec.signal_missing          = cum_n.radius_low;
      st_d.dec.signal_degraded         = cum_n.radius_high || cum_n.deform;
      st_d.dec.tracking_failure        = cum_n.track_err || cum_n.overspeed;
      st_d.dec.sine_wire_open          = cum_n.sin_mean && cum_n.deform && cum_n.track_err;
      st_d.dec.cosine_wire_open        = cum_n.cos_mean && cum_n.deform && cum_n.track_err;
      st_d.dec.excitation_wire_open    = cum_n.radius_low && cum_n.overspeed;
      st_d.dec.sine_wire_shorted       = cum_n.sin_mean && cum_n.track_err;
      st_d.dec.cosine_wire_shorted     = cum_n.cos_mean && cum_n.track_err;
      st_d.dec.excitation_wire_shorted = cum_n.radius_low;

      // ------------------------------------------------------------
      // read side; reads never touch the accumulation
      // ------------------------------------------------------------
      rdv[0]  = f_sx(st_q.sa1);
      rdv[1]  = f_sx(st_q.sa2);
      rdv[2]  = f_sx(st_q.ca1);
      rdv[3]  = f_sx(st_q.ca2);
      rdv[4]  = 32'(st_q.samin);
      rdv[5]  = 32'(st_q.samax);
      rdv[6]  = 32'(st_q.camin);
      rdv[7]  = 32'(st_q.camax);
      rdv[8]  = f_sx(st_q.sm);
      rdv[9]  = f_sx(st_q.cm);
      rdv[10] = f_sx(st_q.smmin);
      rdv[11] = f_sx(st_q.smmax);
      rdv[12] = f_sx(st_q.cmmin);
      rdv[13] = f_sx(st_q.cmmax);
      rdv[14] = 32'(st_q.vec);
      rdv[15] = 32'(st_q.vmin);
      rdv[16] = 32'(st_q.vmax);
      rdv[17] = 32'(st_q.diff);

      st_d.rdata = '0;
      if (bus.rd)
      begin
         if (bus.addr == `RSD_A_CTRL)
         begin
            st_d.rdata[`RSD_CTRL_RUN_BIT] = st_q.run;
         end
         else if (bus.addr == `RSD_A_FACT)
         begin
            st_d.rdata = 32'(st_q.act);
         end
         else if (bus.addr == `RSD_A_FCUM)
         begin
            st_d.rdata = 32'(st_q.cum);
         end
         else if (bus.addr == `RSD_A_DEC)
         begin
            st_d.rdata = {16'h0000,
                          1'b0, 1'b0, st_q.dec[8:3],
                          5'h00, st_q.dec[2:0]};
         end
         else if (bus.addr >= `RSD_A_MEAS0 && moff[1:0] == 2'h0 && midx < 8'(`RSD_NMEAS))
         begin
            st_d.rdata = rdv[midx[4:0]];
         end
         else
         begin
            for (int i = 0; i < `RSD_NLIM; i++)
            begin
               if (bus.addr == 8'(`RSD_A_LIM0 + i * `RSD_WORD))
               begin
                  st_d.rdata = 32'(st_q.lim[i]);
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q <= ST_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rdata     = st_q.rdata;
   assign flags_act = st_q.act;
   assign flags_cum = st_q.cum;
   assign faults    = st_q.dec;
   assign busy      = st_q.calc;

endmodule : rsd_diag
`default_nettype wire

//--- rtl/rsd_cfg.svh
// rsd_cfg.svh: register map, field positions and reset values of the resolver diagnostics
`ifndef RSD_CFG_SVH
`define RSD_CFG_SVH

`define RSD_DW           24
`define RSD_AW           8
`define RSD_NLIM         7
`define RSD_NMEAS        18
`define RSD_WORD         8'h04

`define RSD_A_CTRL       8'h00
`define RSD_A_LIM0       8'h04
`define RSD_A_FACT       8'h20
`define RSD_A_FCUM       8'h24
`define RSD_A_DEC        8'h28
`define RSD_A_MEAS0      8'h30

`define RSD_CTRL_RST_BIT 0
`define RSD_CTRL_RUN_BIT 1
`define RSD_RUN_RST      1'b1

`define RSD_LIM_AMPL     0
`define RSD_LIM_OFFS     1
`define RSD_LIM_RLOW     2
`define RSD_LIM_RHIGH    3
`define RSD_LIM_DEF      4
`define RSD_LIM_TERR     5
`define RSD_LIM_SPD      6

`define RSD_DEC_ADV_LSB  8
`define RSD_HALF_FIRST   1'b0

`endif

//--- rtl/rsd_pkg.sv
// rsd_pkg.sv: shared types of the resolver diagnostics
`default_nettype none
package rsd_pkg;

   // register port request, one cycle per access
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } rsd_bus_s;

   // threshold comparison results, sine amplitude in bit 0
   typedef struct packed {
      logic overspeed;
      logic track_err;
      logic deform;
      logic radius_high;
      logic radius_low;
      logic cos_mean;
      logic sin_mean;
      logic cos_ampl;
      logic sin_ampl;
   } rsd_flags_s;

   // decoded fault flags
   typedef struct packed {
      logic excitation_wire_shorted;
      logic cosine_wire_shorted;
      logic sine_wire_shorted;
      logic excitation_wire_open;
      logic cosine_wire_open;
      logic sine_wire_open;
      logic tracking_failure;
      logic signal_degraded;
      logic signal_missing;
   } rsd_dec_s;

endpackage : rsd_pkg
`default_nettype wire

//--- sim/rsd_diag_properties.sv
// rsd_diag_properties.sv: port-level checks of the resolver diagnostics
`default_nettype none
module rsd_diag_chk
(
   input wire logic                 clk_sys,
   input wire logic                 rstn,
   input wire logic                 upd_valid,
   input wire rsd_pkg::rsd_bus_s    bus,
   input wire logic [31:0]          rdata,
   input wire rsd_pkg::rsd_flags_s  flags_act,
   input wire rsd_pkg::rsd_flags_s  flags_cum,
   input wire rsd_pkg::rsd_dec_s    faults,
   input wire logic                 busy
);
   timeunit 1ns;
   timeprecision 100ps;
   import rsd_pkg::*;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   // ----------------
   // sequences
   // ----------------
   sequence s_pass;
      upd_valid ##1 busy;
   endsequence
   sequence s_diag_rst;
      bus.wr && bus.addr == 8'h00 && bus.wdata[0] && !busy;
   endsequence

   // ----------------
   // properties
   // ----------------
   a_busy_cause: assert property (busy |-> $past(upd_valid))
      else $error("busy without an update");
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
      else $error("read data outside the answer cycle");
   a_pass_ored: assert property (s_pass |=> (flags_cum & flags_act) == flags_act)
      else $error("actual flag missing from cumulative");
   a_cum_hold: assert property (!busy && !(bus.wr && bus.addr == 8'h00 && bus.wdata[0]) |=> $stable(flags_cum))
      else $error("cumulative flags changed without a pass");
   a_cum_clear: assert property (s_diag_rst |=> flags_cum == '0)
      else $error("cumulative flags not cleared");
   a_act_hold: assert property (!busy |=> $stable(flags_act))
      else $error("actual flags changed without a pass");
   a_dec_basic: assert property (faults.signal_missing == flags_cum.radius_low
      && faults.signal_degraded == (flags_cum.radius_high | flags_cum.deform)
      && faults.tracking_failure == (flags_cum.track_err | flags_cum.overspeed))
      else $error("basic decode wrong");
   a_dec_open: assert property (faults.sine_wire_open == (flags_cum.sin_mean & flags_cum.deform & flags_cum.track_err)
      && faults.cosine_wire_open == (flags_cum.cos_mean & flags_cum.deform & flags_cum.track_err)
      && faults.excitation_wire_open == (flags_cum.radius_low & flags_cum.overspeed))
      else $error("open wire decode wrong");
   a_dec_short: assert property (faults.sine_wire_shorted == (flags_cum.sin_mean & flags_cum.track_err)
      && faults.cosine_wire_shorted == (flags_cum.cos_mean & flags_cum.track_err)
      && faults.excitation_wire_shorted == flags_cum.radius_low)
      else $error("short decode wrong");
endmodule : rsd_diag_chk

bind rsd_diag rsd_diag_chk chk (
   .clk_sys   (clk_sys),
   .rstn      (rstn),
   .upd_valid (upd_valid),
   .bus       (bus),
   .rdata     (rdata),
   .flags_act (flags_act),
   .flags_cum (flags_cum),
   .faults    (faults),
   .busy      (busy)
);
`default_nettype wire

//--- sim/rsd_host.sv
// rsd_host.sv: host model on the register port
`default_nettype none
module rsd_host
(
   input  wire logic         clk_sys,
   output var rsd_pkg::rsd_bus_s bus,
   input  wire logic [31:0]  rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   import rsd_pkg::*;

   initial bus = '0;

   // ----------------
   // accesses
   // ----------------
   // idle address and data are inverted so nothing leans on stale values
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus <= '{addr: ~a, wdata: 32'hFFFFFFFF, wr: 1'b0, rd: 1'b0};
      #1 d = rdata;
   endtask : rd
endmodule : rsd_host
`default_nettype wire

//--- sim/tb_top.sv
// tb_top.sv: self-checking bench of the resolver diagnostics
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import rsd_pkg::*;

   logic               clk_sys = 1'b0;
   logic               rstn = 1'b0;
   logic               upd_valid = 1'b0;
   logic               upd_half = 1'b0;
   logic signed [23:0] upd_sin = '0;
   logic signed [23:0] upd_cos = '0;
   logic signed [23:0] upd_ang_err = '0;
   logic signed [23:0] upd_speed = '0;
   rsd_bus_s           bus;
   logic [31:0]        rdata;
   logic [31:0]        rd_v;
   rsd_flags_s         flags_act;
   rsd_flags_s         flags_cum;
   rsd_dec_s           faults;
   logic               busy;
   int                 failures = 0;
   int                 cmp_count = 0;
   int                 cycles = 0;

   initial forever #25 clk_sys = ~clk_sys;

   rsd_diag uut (.clk_sys(clk_sys), .rstn(rstn), .upd_valid(upd_valid), .upd_half(upd_half),
      .upd_sin(upd_sin), .upd_cos(upd_cos), .upd_ang_err(upd_ang_err), .upd_speed(upd_speed),
      .bus(bus), .rdata(rdata), .flags_act(flags_act), .flags_cum(flags_cum), .faults(faults),
      .busy(busy));
   rsd_host host (.clk_sys(clk_sys), .bus(bus), .rdata(rdata));

   // ----------------
   // helpers
   // ----------------
   task automatic print_verdict();
      if (failures == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
      host.rd(a, rd_v);
      chk(n, e, rd_v);
   endtask : rc

   task automatic fl(input logic [8:0] a, input logic [8:0] c, input logic [8:0] f);
      chk("flags_act", {23'h0, a}, {23'h0, flags_act});
      chk("flags_cum", {23'h0, c}, {23'h0, flags_cum});
      chk("faults", {23'h0, f}, {23'h0, faults});
   endtask : fl

   // results are settled one edge after the accepted pulse
   task automatic upd(input logic h, input logic signed [23:0] s, c, e, v);
      @(posedge clk_sys);
      upd_valid <= 1'b1;
      upd_half <= h;
      upd_sin <= s;
      upd_cos <= c;
      upd_ang_err <= e;
      upd_speed <= v;
      @(posedge clk_sys);
      upd_valid <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : upd

   // ----------------
   // scenarios
   // ----------------
   task automatic t_regs();
      rc("ctrl", 8'h00, 32'h00000002);
      rc("ampl_lim", 8'h04, 32'h01FFFFFF);
      rc("rlow_lim", 8'h0C, 32'h0);
      rc("unmapped", 8'h7C, 32'h0);
      rc("cum", 8'h24, 32'h0);
      host.wr(8'h04, 32'h00400000);
      rc("ampl_lim", 8'h04, 32'h00400000);
   endtask : t_regs

   task automatic t_ampl();
      upd(1'b0, 24'sh400000, 24'sh300000, 24'sh0, 24'sh0);
      fl(9'h000, 9'h000, 9'h000);
      upd(1'b1, -24'sh400001, -24'sh300000, 24'sh0, 24'sh0);
      fl(9'h001, 9'h001, 9'h000);
      rc("sin_ampl_1", 8'h30, 32'h00400000);
      rc("sin_ampl_2", 8'h34, 32'hFFBFFFFF);
      rc("sin_mean", 8'h50, 32'hFFFFFFFF);
      rc("radius", 8'h68, 32'h00320001);
      upd(1'b1, 24'sh0, 24'sh0, 24'sh0, 24'sh0);
      fl(9'h000, 9'h001, 9'h000);
      rc("sin_min", 8'h40, 32'h0);
      rc("sin_max", 8'h44, 32'h00400001);
      rc("rsq_max", 8'h70, 32'h00320001);
   endtask : t_ampl

   task automatic t_diag_reset();
      host.wr(8'h00, 32'h00000003);
      rc("cum", 8'h24, 32'h0);
      rc("sin_max", 8'h44, 32'h0);
      upd(1'b0, 24'sh200000, 24'sh200000, 24'sh0, 24'sh0);
      rc("sin_min", 8'h40, 32'h00200000);
      rc("sin_max", 8'h44, 32'h00200000);
      // run off: an update must leave every result untouched
      host.wr(8'h00, 32'h00000000);
      upd(1'b0, 24'sh7FFFFF, 24'sh0, 24'sh0, 24'sh0);
      fl(9'h000, 9'h000, 9'h000);
      rc("ctrl", 8'h00, 32'h0);
      rc("sin_max", 8'h44, 32'h00200000);
      host.wr(8'h00, 32'h00000002);
   endtask : t_diag_reset

   task automatic t_decode();
      host.wr(8'h08, 32'h0007FFFF);
      host.wr(8'h0C, 32'h00020001);
      host.wr(8'h10, 32'h0001FFFF);
      host.wr(8'h14, 32'h000FFFFF);
      host.wr(8'h18, 32'h00000100);
      host.wr(8'h1C, 32'h00000100);
      host.wr(8'h00, 32'h00000003);
      upd(1'b0, 24'sh100000, 24'sh0, -24'sh101, 24'sh100);
      fl(9'h0F4, 9'h0F4, 9'h14F);
      rc("radius", 8'h68, 32'h00020000);
      rc("deform", 8'h74, 32'h00100000);
      rc("decode", 8'h28, 32'h00002907);
      upd(1'b0, 24'sh100000, 24'sh0, -24'sh101, -24'sh101);
      fl(9'h1F4, 9'h1F4, 9'h16F);
      host.wr(8'h00, 32'h00000003);
      upd(1'b0, 24'sh0, 24'sh100000, -24'sh101, 24'sh0);
      fl(9'h0F8, 9'h0F8, 9'h197);
      rc("decode", 8'h28, 32'h00003207);
   endtask : t_decode

   // ----------------
   // run control
   // ----------------
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         failures = failures + 1;
         print_verdict();
      end
   end

   initial
   begin
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      t_regs();
      t_ampl();
      t_diag_reset();
      t_decode();
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
